// >>> parallel_hotplug_slot_control.sv
// Notes on behaviour
// - slot 1 power enable is driven only in the 1111, 1001 and 1010 configurations.
// - slot 2 power enable is driven only in dual-slot parallel mode 1010.
// - an enabled slot 1 fault resets and isolates slot 1 at once.
// - in 1010 only, an enabled slot 2 fault resets and isolates slot 2 at once.
// - slot 1 active-low green indicator is driven in the three parallel modes.
// - slot 2 active-low green indicator is driven only in mode 1010.
// - slot 1 active-low reset is driven in the three parallel modes.
// - slot 2 active-low reset is driven only in mode 1010.
// - the smbus address is 1, 1, strap 5, 0, straps 3 to 1, from bit 7 down.
// - straps are taken on the rising edge of power good, then the pins return to use.
// - the top strap bit enables hot plug when high and disables it when low.
`timescale 1ns/1ps
module parallel_hotplug_slot_control (
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst,
   // apb slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // power good and straps
   input  wire logic          power_good,
   input  wire logic [3:0]    slot_config_strap,
   input  wire logic          smb_strap5,
   input  wire logic [2:0]    smb_strap_low,
   // slot 1
   input  wire logic          slot1_power_fault_n,
   output logic               slot1_power_enable,
   output logic               slot1_power_indicator_n,
   output logic               slot1_reset_n,
   output logic               slot1_isolate,
   // slot 2
   input  wire logic          slot2_power_fault_n,
   output logic               slot2_power_enable,
   output logic               slot2_power_indicator_n,
   output logic               slot2_reset_n,
   output logic               slot2_isolate,
   // smbus target address and interrupt
   output logic [6:0]         smb_target_address,
   output logic               irq
);

   // ****************************************
   // declarations
   // ****************************************
   slot_ctrl_pkg::strap_t      straps;
   slot_ctrl_pkg::slot_ctl_t   slot1_ctl;
   slot_ctrl_pkg::slot_ctl_t   slot2_ctl;
   slot_ctrl_pkg::slot_pins_t  slot1_pins;
   slot_ctrl_pkg::slot_pins_t  slot2_pins;
   logic [7:0]                 control;
   logic [7:0]                 next_control;
   logic [2:0]                 int_status;
   logic [2:0]                 next_int_status;
   logic [2:0]                 int_enable;
   logic [2:0]                 next_int_enable;
   logic [2:0]                 int_events;
   logic [2:0]                 int_clear;
   logic                       capture_pulse;
   logic                       slot1_mode_ok;
   logic                       slot2_mode_ok;
   logic                       slot1_fault_latched;
   logic                       slot2_fault_latched;
   logic                       slot1_fault_event;
   logic                       slot2_fault_event;
   logic                       access;
   logic                       wr_access;
   logic                       rd_access;
   logic                       hit_control;
   logic                       hit_status;
   logic                       hit_int_status;
   logic                       hit_int_enable;
   logic                       hit_int_clear;
   logic                       hit_smb_addr;
   logic                       hit_any;
   logic                       read_only_hit;
   logic [31:0]                status_word;
   logic [31:0]                read_word;

   // ****************************************
   // strap sampling
   // ****************************************

   strap_capture u_strap_capture (
      .ref_clk           (ref_clk),
      .rst               (rst),
      .power_good        (power_good),
      .slot_config_strap (slot_config_strap),
      .smb_strap5        (smb_strap5),
      .smb_strap_low     (smb_strap_low),
      .straps            (straps),
      .capture_pulse     (capture_pulse)
   );

   // ****************************************
   // mode qualification
   // ****************************************

   assign slot1_mode_ok = straps.captured && slot_ctrl_pkg::slot1_allowed(straps.slot_config);
   assign slot2_mode_ok = straps.captured && slot_ctrl_pkg::slot2_allowed(straps.slot_config);

   // ****************************************
   // smbus address
   // ****************************************

   assign smb_target_address = {slot_ctrl_pkg::smb_bit7, slot_ctrl_pkg::smb_bit6, straps.smb_bit5,
                                slot_ctrl_pkg::smb_bit4, straps.smb_low};

   // ****************************************
   // apb decode
   // ****************************************

   // access phase qualifiers
   assign access    = psel && penable;
   assign wr_access = access && pwrite;
   assign rd_access = access && !pwrite;

   // address hits
   assign hit_control    = (paddr == slot_ctrl_pkg::control_offset);
   assign hit_status     = (paddr == slot_ctrl_pkg::status_offset);
   assign hit_int_status = (paddr == slot_ctrl_pkg::int_status_offset);
   assign hit_int_enable = (paddr == slot_ctrl_pkg::int_enable_offset);
   assign hit_int_clear  = (paddr == slot_ctrl_pkg::int_clear_offset);
   assign hit_smb_addr   = (paddr == slot_ctrl_pkg::smb_addr_offset);
   assign hit_any        = hit_control || hit_status || hit_int_status ||
                           hit_int_enable || hit_int_clear || hit_smb_addr;
   assign read_only_hit  = hit_status || hit_int_status || hit_smb_addr;

   // zero wait states; error on unmapped or writes to read-only words
   assign pready  = access;
   assign pslverr = access && (!hit_any || (pwrite && read_only_hit));

   // ****************************************
   // control and enable registers
   // ****************************************

   // software writes to control and interrupt enable
   assign next_control    = (wr_access && hit_control) ? pwdata[7:0] : control;
   assign next_int_enable = (wr_access && hit_int_enable) ? pwdata[2:0] : int_enable;

   // control fields per slot
   assign slot1_ctl = control[slot_ctrl_pkg::slot1_ctl_lsb +: 4];
   assign slot2_ctl = control[slot_ctrl_pkg::slot2_ctl_lsb +: 4];

   // software register storage
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         control    <= slot_ctrl_pkg::control_reset;
         int_enable <= slot_ctrl_pkg::int_enable_reset;
      end else begin
         control    <= next_control;
         int_enable <= next_int_enable;
      end
   end

   // ****************************************
   // slot logic
   // ****************************************

   slot_unit u_slot1 (
      .ref_clk       (ref_clk),
      .rst           (rst),
      .allowed       (slot1_mode_ok),
      .ctl           (slot1_ctl),
      .power_fault_n (slot1_power_fault_n),
      .pins          (slot1_pins),
      .fault_latched (slot1_fault_latched),
      .fault_event   (slot1_fault_event)
   );

   slot_unit u_slot2 (
      .ref_clk       (ref_clk),
      .rst           (rst),
      .allowed       (slot2_mode_ok),
      .ctl           (slot2_ctl),
      .power_fault_n (slot2_power_fault_n),
      .pins          (slot2_pins),
      .fault_latched (slot2_fault_latched),
      .fault_event   (slot2_fault_event)
   );

   // ****************************************
   // slot pins
   // ****************************************

   assign slot1_power_enable      = slot1_pins.power_enable;
   assign slot1_power_indicator_n = slot1_pins.indicator_n;
   assign slot1_reset_n           = slot1_pins.reset_n;
   assign slot1_isolate           = slot1_pins.isolate;

   assign slot2_power_enable      = slot2_pins.power_enable;
   assign slot2_power_indicator_n = slot2_pins.indicator_n;
   assign slot2_reset_n           = slot2_pins.reset_n;
   assign slot2_isolate           = slot2_pins.isolate;

   // ****************************************
   // interrupts
   // ****************************************

   // event sources
   assign int_events[slot_ctrl_pkg::irq_slot1_fault] = slot1_fault_event;
   assign int_events[slot_ctrl_pkg::irq_slot2_fault] = slot2_fault_event;
   assign int_events[slot_ctrl_pkg::irq_straps_done] = capture_pulse;

   // write-one-to-clear, a new event wins over the clear
   assign int_clear       = (wr_access && hit_int_clear) ? pwdata[2:0] : 3'h0;
   assign next_int_status = int_events | (int_status & ~int_clear);

   // sticky status
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         int_status <= 3'h0;
      end else begin
         int_status <= next_int_status;
      end
   end

   // level interrupt while any enabled bit is set
   assign irq = |(int_status & int_enable);

   // ****************************************
   // read data
   // ****************************************

   // live status word
   assign status_word = {21'h000000,
                         slot2_power_fault_n,
                         slot1_power_fault_n,
                         slot2_fault_latched,
                         slot1_fault_latched,
                         slot2_mode_ok,
                         slot1_mode_ok,
                         straps.captured,
                         straps.slot_config};

   // read mux; write-only and unmapped words read zero
   assign read_word = hit_control    ? {24'h000000, control} :
                      hit_status     ? status_word :
                      hit_int_status ? {29'h00000000, int_status} :
                      hit_int_enable ? {29'h00000000, int_enable} :
                      hit_smb_addr   ? {25'h0000000, smb_target_address} :
                      32'h00000000;

   // read data only during a read access
   assign prdata = rd_access ? read_word : 32'h00000000;

endmodule : parallel_hotplug_slot_control

// >>> slot_ctrl_pkg.sv
package slot_ctrl_pkg;

   // ****************************************
   // register map, byte addresses
   // ****************************************
   localparam logic [7:0] control_offset    = 8'h00;
   localparam logic [7:0] status_offset     = 8'h04;
   localparam logic [7:0] int_status_offset = 8'h08;
   localparam logic [7:0] int_enable_offset = 8'h0c;
   localparam logic [7:0] int_clear_offset  = 8'h10;
   localparam logic [7:0] smb_addr_offset   = 8'h14;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0]  control_reset    = 8'h00;
   localparam logic [2:0]  int_enable_reset = 3'h0;
   localparam logic [3:0]  strap_reset      = 4'h0;

   // ****************************************
   // control register field positions
   // ****************************************
   localparam int slot1_ctl_lsb = 0;
   localparam int slot2_ctl_lsb = 4;

   // ****************************************
   // interrupt bit positions
   // ****************************************
   localparam int irq_slot1_fault = 0;
   localparam int irq_slot2_fault = 1;
   localparam int irq_straps_done = 2;

   // ****************************************
   // slot configuration strap encodings
   // ****************************************
   localparam logic [3:0] cfg_one_slot_no_glue = 4'hf;
   localparam logic [3:0] cfg_single_parallel  = 4'h9;
   localparam logic [3:0] cfg_dual_parallel    = 4'ha;
   localparam int         cfg_hotplug_bit      = 3;

   // ****************************************
   // smbus target address fixed bits
   // ****************************************
   localparam logic smb_bit7 = 1'b1;
   localparam logic smb_bit6 = 1'b1;
   localparam logic smb_bit4 = 1'b0;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic fault_enable;
      logic reset_release;
      logic indicator_on;
      logic power_on;
   } slot_ctl_t;

   typedef struct packed {
      logic power_enable;
      logic indicator_n;
      logic reset_n;
      logic isolate;
   } slot_pins_t;

   typedef struct packed {
      logic [3:0] slot_config;
      logic [2:0] smb_low;
      logic       smb_bit5;
      logic       captured;
   } strap_t;

   // slot 1 runs in any of the three parallel modes
   function automatic logic slot1_allowed(input logic [3:0] cfg);
      slot1_allowed = cfg[cfg_hotplug_bit] &&
                      (cfg == cfg_one_slot_no_glue || cfg == cfg_single_parallel ||
                       cfg == cfg_dual_parallel);
   endfunction : slot1_allowed

   // slot 2 runs only in dual-slot parallel mode
   function automatic logic slot2_allowed(input logic [3:0] cfg);
      slot2_allowed = cfg[cfg_hotplug_bit] && (cfg == cfg_dual_parallel);
   endfunction : slot2_allowed

endpackage : slot_ctrl_pkg

// >>> slot_ctrl_props.sv
`timescale 1ns/1ps
module slot_ctrl_props (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   // straps and address
   input wire logic        power_good,
   input wire logic        smb_strap5,
   input wire logic [2:0]  smb_strap_low,
   input wire logic [6:0]  smb_target_address,
   // slots and interrupt
   input wire logic        slot1_power_fault_n,
   input wire logic        slot1_power_enable,
   input wire logic        slot1_power_indicator_n,
   input wire logic        slot1_reset_n,
   input wire logic        slot1_isolate,
   input wire logic        slot2_power_fault_n,
   input wire logic        slot2_power_enable,
   input wire logic        slot2_reset_n,
   input wire logic        slot2_isolate,
   input wire logic        irq
);
   logic [7:0] sh_ctl;
   logic [2:0] sh_ien;
   // completed writes and live enabled faults
   wire acc    = psel && penable && pwrite && pready;
   wire ctl_wr = acc && paddr == slot_ctrl_pkg::control_offset;
   wire ien_wr = acc && paddr == slot_ctrl_pkg::int_enable_offset;
   wire f1     = sh_ctl[3] && !slot1_power_fault_n && slot1_power_enable;
   wire f2     = sh_ctl[7] && !slot2_power_fault_n && slot2_power_enable;
   // shadow of control and interrupt enable
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sh_ctl <= 8'h00;
         sh_ien <= 3'h0;
      end else begin
         if (ctl_wr) sh_ctl <= pwdata[7:0];
         if (ien_wr) sh_ien <= pwdata[2:0];
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ******
   // properties
   // ******
   AST_SMB_FIXED: assert property (smb_target_address[6:5] == 2'b11 && !smb_target_address[3])
      else $error("fixed address bits wrong");
   AST_SMB_CAPTURE: assert property ($rose(power_good) ##1 ($stable(smb_strap5) && $stable(smb_strap_low))
      |=> {smb_target_address[4], smb_target_address[2:0]} == {$past(smb_strap5), $past(smb_strap_low)})
      else $error("straps not captured");
   AST_APB_READY: assert property (pready == (psel && penable))
      else $error("ready not zero wait");
   AST_F1_ISOLATE: assert property (f1 |-> !slot1_reset_n && slot1_isolate)
      else $error("slot 1 fault not isolated");
   AST_F2_ISOLATE: assert property (f2 |-> !slot2_reset_n && slot2_isolate)
      else $error("slot 2 fault not isolated");
   AST_F1_POWER_OFF: assert property (f1 |=> !slot1_power_enable)
      else $error("slot 1 power kept on fault");
   AST_PWR1: assert property (slot1_power_enable |-> $past(sh_ctl[0]))
      else $error("slot 1 power without request");
   AST_PWR2: assert property (slot2_power_enable |-> $past(sh_ctl[4]))
      else $error("slot 2 power without request");
   AST_IND1: assert property (!slot1_power_indicator_n |-> $past(sh_ctl[1]))
      else $error("slot 1 indicator without request");
   AST_RST1: assert property (slot1_reset_n && slot1_power_enable |-> sh_ctl[2] || $past(sh_ctl[2]))
      else $error("slot 1 reset released early");
   AST_IRQ_FAULT: assert property (f1 && sh_ien[0] |=> irq)
      else $error("fault interrupt missing");
   // main scenarios
   cover property (f1);
   cover property (f2);
   cover property (slot2_power_enable && !slot2_reset_n);
endmodule : slot_ctrl_props

bind parallel_hotplug_slot_control slot_ctrl_props i_slot_ctrl_props (
   .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .power_good, .smb_strap5, .smb_strap_low,
   .smb_target_address, .slot1_power_fault_n, .slot1_power_enable, .slot1_power_indicator_n, .slot1_reset_n,
   .slot1_isolate, .slot2_power_fault_n, .slot2_power_enable, .slot2_reset_n, .slot2_isolate, .irq);

// >>> slot_power_model.sv
`timescale 1ns/1ps
module slot_power_model (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // slot power and fault
   input  wire logic power_enable,
   input  wire logic trip,
   output logic      power_fault_n
);
   logic tripped;
   // over-current latches while powered, clears when power is removed
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) tripped <= 1'b0;
      else tripped <= power_enable && (tripped || trip);
   end
   // fault flag follows the load at once
   assign power_fault_n = !(tripped || (trip && power_enable));
endmodule : slot_power_model

// >>> slot_unit.sv
`timescale 1ns/1ps
module slot_unit (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   // mode qualification and software control
   input  wire logic                   allowed,
   input  slot_ctrl_pkg::slot_ctl_t    ctl,
   // slot side
   input  wire logic                   power_fault_n,
   output slot_ctrl_pkg::slot_pins_t   pins,
   // state
   output logic                        fault_latched,
   output logic                        fault_event
);

   logic fault_now;
   logic next_fault_latched;
   logic next_power_enable;
   logic next_indicator_n;
   logic power_enable_reg;
   logic indicator_n_reg;
   logic reset_n_now;
   logic isolate_now;

   // live qualified fault
   assign fault_now = allowed && ctl.fault_enable && !power_fault_n;

   // sticky fault, set wins over clear by power-off
   assign next_fault_latched = fault_now || (fault_latched && ctl.power_on);
   assign fault_event        = fault_now && !fault_latched;

   // power drops on fault; unused slot stays off
   assign next_power_enable = allowed && ctl.power_on && !fault_now && !fault_latched;
   assign next_indicator_n  = !(allowed && ctl.indicator_on);

   // fault reset and isolation act at once, not a cycle later
   assign reset_n_now = !allowed || (ctl.reset_release && !fault_now && !fault_latched);
   assign isolate_now = allowed && (fault_now || fault_latched);

   // one driver for the whole pin bundle
   assign pins = slot_ctrl_pkg::slot_pins_t'{power_enable: power_enable_reg, indicator_n: indicator_n_reg,
                                             reset_n: reset_n_now, isolate: isolate_now};

   // registered slot outputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fault_latched    <= 1'b0;
         power_enable_reg <= 1'b0;
         indicator_n_reg  <= 1'b1;
      end else begin
         fault_latched    <= next_fault_latched;
         power_enable_reg <= next_power_enable;
         indicator_n_reg  <= next_indicator_n;
      end
   end

endmodule : slot_unit

// >>> strap_capture.sv
`timescale 1ns/1ps
module strap_capture (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   // strap pins and power good
   input  wire logic                   power_good,
   input  wire logic [3:0]             slot_config_strap,
   input  wire logic                   smb_strap5,
   input  wire logic [2:0]             smb_strap_low,
   // captured values
   output slot_ctrl_pkg::strap_t       straps,
   output logic                        capture_pulse
);

   logic       power_good_prev;
   logic       power_good_rise;
   slot_ctrl_pkg::strap_t next_straps;

   // rising edge of power good
   assign power_good_rise = power_good && !power_good_prev;

   assign next_straps = power_good_rise ?
                        slot_ctrl_pkg::strap_t'{slot_config: slot_config_strap, smb_low: smb_strap_low,
                          smb_bit5: smb_strap5, captured: 1'b1} : straps;

   // edge history
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         power_good_prev <= 1'b0;
      end else begin
         power_good_prev <= power_good;
      end
   end

   // strap latch, reloaded on every rising edge of power good, held in between
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         straps        <= '{slot_config: slot_ctrl_pkg::strap_reset, smb_low: 3'h0,
                            smb_bit5: 1'b0, captured: 1'b0};
         capture_pulse <= 1'b0;
      end else begin
         straps        <= next_straps;
         capture_pulse <= power_good_rise;
      end
   end

endmodule : strap_capture

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // ******
   // stimulus, design and slots
   // ******
   logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        power_good = 1'b0, smb_strap5 = 1'b0, trip1 = 1'b0, trip2 = 1'b0, a1, a2, e;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [3:0]  slot_config_strap = 4'h0;
   logic [2:0]  smb_strap_low = 3'h0;
   logic        pready, pslverr, f1_n, f2_n, pe1, pe2, led1_n, led2_n, r1_n, r2_n, iso1, iso2, irq;
   logic [6:0]  smb_addr;
   logic [3:0]  cfgs[7] = '{4'hf, 4'h9, 4'h2, 4'h1, 4'hb, 4'h0, 4'ha};
   int          mismatches = 0, checks = 0;
   // clock
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   parallel_hotplug_slot_control i_parallel_hotplug_slot_control (
      .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .power_good,
      .slot_config_strap, .smb_strap5, .smb_strap_low, .slot1_power_fault_n(f1_n), .slot1_power_enable(pe1),
      .slot1_power_indicator_n(led1_n), .slot1_reset_n(r1_n), .slot1_isolate(iso1), .slot2_power_fault_n(f2_n),
      .slot2_power_enable(pe2), .slot2_power_indicator_n(led2_n), .slot2_reset_n(r2_n), .slot2_isolate(iso2),
      .smb_target_address(smb_addr), .irq);
   slot_power_model m1 (.ref_clk, .rst, .power_enable(pe1), .trip(trip1), .power_fault_n(f1_n));
   slot_power_model m2 (.ref_clk, .rst, .power_enable(pe2), .trip(trip2), .power_fault_n(f2_n));
   // ******
   // tasks
   // ******
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // one apb transfer, released after pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         wrap_up();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
      chk(32'(e), 32'(err));
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : cyc
   // ******
   // sequence
   // ******
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      cyc(1);
      chk(32'({pe1, led1_n, r1_n, iso1, pe2, led2_n, r2_n, iso2, irq}), 32'h0cc);
      chk(32'(smb_addr), 32'h60);
      rd(slot_ctrl_pkg::control_offset, 32'h0, 1'b0);
      $display("reset test done");
      foreach (cfgs[i]) begin
         a1 = cfgs[i] == 4'hf || cfgs[i] == 4'h9 || cfgs[i] == 4'ha;
         a2 = cfgs[i] == 4'ha;
         wr(slot_ctrl_pkg::control_offset, 32'h0);
         power_good <= 1'b0;
         slot_config_strap <= cfgs[i];
         smb_strap5 <= i[0];
         smb_strap_low <= 3'(i) ^ 3'h5;
         cyc(2);
         @(posedge ref_clk);
         power_good <= 1'b1;
         cyc(4);
         chk(32'(smb_addr), 32'({2'b11, i[0], 1'b0, 3'(i) ^ 3'h5}));
         chk(32'({pe1, led1_n, r1_n, pe2, led2_n, r2_n}), 32'({2'b01, !a1, 2'b01, !a2}));
         chk(32'({led2_n, r2_n}), 32'({1'b1, !a2}));
         rd(slot_ctrl_pkg::status_offset, 32'h600 | 32'({a2, a1, 1'b1, cfgs[i]}), 1'b0);
         wr(slot_ctrl_pkg::control_offset, 32'h77);
         cyc(2);
         chk(32'({pe1, led1_n, r1_n, iso1}), 32'({a1, !a1, 2'b10}));
         chk(32'({pe2, led2_n, r2_n, iso2}), 32'({a2, !a2, 2'b10}));
         chk(32'(led2_n), 32'(!a2));
      end
      $display("mode test done");
      wr(slot_ctrl_pkg::int_enable_offset, 32'h3);
      wr(slot_ctrl_pkg::int_clear_offset, 32'h7);
      wr(slot_ctrl_pkg::control_offset, 32'hff);
      trip1 <= 1'b1;
      @(negedge ref_clk);
      chk(32'({r1_n, iso1, pe1, r2_n, iso2}), 32'h0e);
      cyc(1);
      chk(32'({pe1, irq, pe2}), 32'h3);
      rd(slot_ctrl_pkg::int_status_offset, 32'h1, 1'b0);
      trip1 <= 1'b0;
      wr(slot_ctrl_pkg::control_offset, 32'hfe);
      wr(slot_ctrl_pkg::int_clear_offset, 32'h1);
      cyc(1);
      chk(32'({irq, r1_n, iso1}), 32'h2);
      wr(slot_ctrl_pkg::control_offset, 32'hff);
      cyc(2);
      chk(32'(pe1), 32'h1);
      $display("slot 1 fault test done");
      wr(slot_ctrl_pkg::control_offset, 32'h7f);
      trip2 <= 1'b1;
      cyc(2);
      chk(32'({pe2, r2_n, iso2, irq}), 32'hc);
      wr(slot_ctrl_pkg::control_offset, 32'hff);
      @(negedge ref_clk);
      chk(32'({r2_n, iso2}), 32'h1);
      cyc(1);
      chk(32'({pe2, irq}), 32'h1);
      trip2 <= 1'b0;
      wr(slot_ctrl_pkg::control_offset, 32'h0f);
      $display("slot 2 fault test done");
      smb_strap5 <= 1'b1;
      smb_strap_low <= 3'h4;
      cyc(2);
      rd(slot_ctrl_pkg::smb_addr_offset, 32'h63, 1'b0);
      rd(8'h18, 32'h0, 1'b1);
      rd(slot_ctrl_pkg::int_clear_offset, 32'h0, 1'b0);
      apb(1'b1, slot_ctrl_pkg::status_offset, 32'hffffffff);
      chk(32'(e), 32'h1);
      $display("bus test done");
      wrap_up();
   end
endmodule : tb_top
